// ===== core/crs_branch_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"

module crs_branch_test (
    // Status and condition
    input wire logic [7:0] i_ps,
    input wire crs_pkg::crs_cond_type i_cond,
    input wire logic i_want,
    // Decision
    output logic o_take
);
    import crs_pkg::*;

    logic flag;

    // Select the tested flag and compare with wanted level
    always_comb begin
        case (i_cond)
            COND_C: flag = i_ps[`CRS_FLAG_C];
            COND_Z: flag = i_ps[`CRS_FLAG_Z];
            COND_V: flag = i_ps[`CRS_FLAG_V];
            default: flag = i_ps[`CRS_FLAG_N];
        endcase
        o_take = (flag == i_want);
    end

endmodule
`default_nettype wire

// ===== core/crs_core_regs.sv
// Overview of operation
// - Interrupt inhibit flag reads one when reset is released.
// - Program counter high byte from FFFF, low byte from FFFE at reset.
// - Other registers need no defined reset value.
// - Eight-bit accumulator holds operands and results.
// - First eight-bit index register forms indexed addresses.
// - Second eight-bit index register forms indexed addresses for some operations.
// - Eight-bit stack pointer gives low byte of stack address.
// - Stack high byte is 00 or 01 by page select bit.
// - Page select is bit 2 of mode register at FB, cleared by reset.
// - Push and pull operations exist for accumulator and status.
// - Sixteen-bit program counter holds next fetch address.
// - Status is eight bits: four result flags, four control flags.
// - Branches test carry, zero, overflow and negative flags.
// - Zero, overflow and negative have no meaning in decimal mode.
// - Carry at bit 0 takes arithmetic carry, shifts and rotates too.
// - Carry assert sets carry, carry clear resets it.
// - No fast-clock or slow-clock selection operations.
// - Product, divide, wait and halt operations are present.
// - Exactly six internal registers.
// - Interrupt inhibit at bit 2 blocks all but break; set on accept.
// - Decimal flag at bit 3 selects decimal or binary arithmetic.
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"

module crs_core_regs (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Operation request from decoder
    input wire logic i_op_valid,
    input wire crs_pkg::crs_op_type i_op,
    input wire logic [7:0] i_data,
    input wire logic [15:0] i_pc_load,
    input wire logic i_wake,
    // Arithmetic unit results
    input wire logic [7:0] i_alu_result,
    input wire logic i_alu_carry,
    input wire logic i_alu_ovf,
    // Memory port, asynchronous read
    input wire logic [7:0] i_mem_rdata,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    // Zero-page register port
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // Interrupt gating
    input wire logic i_irq_req,
    input wire logic i_break_req,
    output logic o_irq_take,
    // Branch test
    input wire crs_pkg::crs_cond_type i_br_cond,
    input wire logic i_br_want,
    output logic o_br_take,
    // Register contents and status
    output logic [7:0] o_acc,
    output logic [7:0] o_idx_x,
    output logic [7:0] o_idx_y,
    output logic [7:0] o_stack_ptr,
    output logic [15:0] o_stack_addr,
    output logic [15:0] o_program_counter,
    output logic [7:0] o_processor_status,
    output logic o_decimal,
    output logic o_ready,
    output logic o_waiting,
    output logic o_halted
);
    import crs_pkg::*;

    localparam crs_regs_type REGS_RST = '{
        st: S_VEC_LO,
        acc: 8'h00,
        idx_x: 8'h00,
        idx_y: 8'h00,
        sp: 8'h00,
        ps: `CRS_PS_RST,
        pc: 16'h0000,
        stk_page: 1'b0,
        pull_to_ps: 1'b0,
        mem_rd: 1'b1,
        mem_wr: 1'b0,
        mem_addr: `CRS_VEC_LO,
        mem_wdata: 8'h00
    };

    crs_regs_type state_r;
    crs_regs_type state_nxt;
    logic op_take;
    logic [7:0] stk_hi;
    logic [15:0] prod;
    logic [15:0] dvd;
    logic [15:0] quo;
    logic [15:0] rem;

    // Request accepted only when idle in run state
    assign op_take = i_op_valid && (state_r.st == S_RUN);

    // Stack high byte from page select
    assign stk_hi = state_r.stk_page ? `CRS_PAGE1_HI : `CRS_PAGE0_HI;

    // Product and quotient of the multiply and divide operations
    assign prod = {8'h00, state_r.acc} * {8'h00, i_data};
    assign dvd = {state_r.idx_y, state_r.acc};
    assign quo = (i_data != 8'h00) ? dvd / {8'h00, i_data} : 16'h0000;
    assign rem = (i_data != 8'h00) ? dvd % {8'h00, i_data} : 16'h0000;

    // Next state of the whole register set
    always_comb begin
        state_nxt = state_r;
        state_nxt.mem_rd = 1'b0;
        state_nxt.mem_wr = 1'b0;
        if (i_sfr_wr && (i_sfr_addr == `CRS_MODE_ADDR)) begin
            state_nxt.stk_page = i_sfr_wdata[`CRS_STK_PAGE_BIT];
        end
        case (state_r.st)
            S_VEC_LO: begin
                state_nxt.pc[7:0] = i_mem_rdata;
                state_nxt.mem_rd = 1'b1;
                state_nxt.mem_addr = `CRS_VEC_HI;
                state_nxt.st = S_VEC_HI;
            end
            S_VEC_HI: begin
                state_nxt.pc[15:8] = i_mem_rdata;
                state_nxt.st = S_RUN;
            end
            S_PULL: begin
                if (state_r.pull_to_ps) begin
                    state_nxt.ps = i_mem_rdata;
                end else begin
                    state_nxt.acc = i_mem_rdata;
                end
                state_nxt.st = S_RUN;
            end
            S_WAIT: begin
                if (i_wake) begin
                    state_nxt.st = S_RUN;
                end
            end
            S_HALT: begin
                state_nxt.st = S_HALT;
            end
            default: begin
                if (op_take) begin
                    case (i_op)
                        OP_LD_ACC: state_nxt.acc = i_data;
                        OP_LD_X: state_nxt.idx_x = i_data;
                        OP_LD_Y: state_nxt.idx_y = i_data;
                        OP_LD_SP: state_nxt.sp = i_data;
                        OP_ALU, OP_SHIFT: begin
                            state_nxt.acc = i_alu_result;
                            state_nxt.ps[`CRS_FLAG_C] = i_alu_carry;
                            if (!state_r.ps[`CRS_FLAG_D]) begin
                                state_nxt.ps[`CRS_FLAG_Z] = (i_alu_result == 8'h00);
                                state_nxt.ps[`CRS_FLAG_N] = i_alu_result[7];
                                if (i_op == OP_ALU) begin
                                    state_nxt.ps[`CRS_FLAG_V] = i_alu_ovf;
                                end
                            end
                        end
                        OP_CARRY_ASSERT: state_nxt.ps[`CRS_FLAG_C] = 1'b1;
                        OP_CARRY_CLEAR: state_nxt.ps[`CRS_FLAG_C] = 1'b0;
                        OP_ACC_PUSH, OP_FLAGS_PUSH: begin
                            state_nxt.mem_wr = 1'b1;
                            state_nxt.mem_addr = {stk_hi, state_r.sp};
                            state_nxt.mem_wdata = (i_op == OP_ACC_PUSH) ? state_r.acc : state_r.ps;
                            state_nxt.sp = state_r.sp - 8'h01;
                        end
                        OP_ACC_POP, OP_FLAGS_POP: begin
                            state_nxt.sp = state_r.sp + 8'h01;
                            state_nxt.mem_rd = 1'b1;
                            state_nxt.mem_addr = {stk_hi, state_r.sp + 8'h01};
                            state_nxt.pull_to_ps = (i_op == OP_FLAGS_POP);
                            state_nxt.st = S_PULL;
                        end
                        OP_INT_ACCEPT, OP_INT_SET: state_nxt.ps[`CRS_FLAG_I] = 1'b1;
                        OP_INT_CLR: state_nxt.ps[`CRS_FLAG_I] = 1'b0;
                        OP_DEC_SET: state_nxt.ps[`CRS_FLAG_D] = 1'b1;
                        OP_DEC_CLR: state_nxt.ps[`CRS_FLAG_D] = 1'b0;
                        OP_PC_INC: state_nxt.pc = state_r.pc + 16'h0001;
                        OP_PC_LOAD: state_nxt.pc = i_pc_load;
                        OP_PRODUCT: begin
                            state_nxt.acc = prod[7:0];
                            state_nxt.idx_y = prod[15:8];
                        end
                        OP_DIVIDE: begin
                            if (i_data != 8'h00) begin
                                state_nxt.acc = quo[7:0];
                                state_nxt.idx_y = rem[7:0];
                            end
                        end
                        OP_WAIT: state_nxt.st = S_WAIT;
                        OP_HALT: state_nxt.st = S_HALT;
                        default: state_nxt.st = S_RUN;
                    endcase
                end
            end
        endcase
    end

    // State register; undefined registers still reset to zero for clean simulation
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= REGS_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Branch condition evaluation
    crs_branch_test u_branch (
        .i_ps(state_r.ps),
        .i_cond(i_br_cond),
        .i_want(i_br_want),
        .o_take(o_br_take)
    );

    // Interrupt gating: break always passes
    assign o_irq_take = (i_irq_req && !state_r.ps[`CRS_FLAG_I]) || i_break_req;

    // Output drive
    assign o_mem_rd = state_r.mem_rd;
    assign o_mem_wr = state_r.mem_wr;
    assign o_mem_addr = state_r.mem_addr;
    assign o_mem_wdata = state_r.mem_wdata;
    assign o_sfr_rdata = (i_sfr_addr == `CRS_MODE_ADDR) ? {5'h00, state_r.stk_page, 2'h0} : 8'h00;
    assign o_acc = state_r.acc;
    assign o_idx_x = state_r.idx_x;
    assign o_idx_y = state_r.idx_y;
    assign o_stack_ptr = state_r.sp;
    assign o_stack_addr = {stk_hi, state_r.sp};
    assign o_program_counter = state_r.pc;
    assign o_processor_status = state_r.ps;
    assign o_decimal = state_r.ps[`CRS_FLAG_D];
    assign o_ready = (state_r.st == S_RUN);
    assign o_waiting = (state_r.st == S_WAIT);
    assign o_halted = (state_r.st == S_HALT);

    // Checks on the register set
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // Inhibit held through the vector fetch
    property p_inhibit_reset;
        (state_r.st == S_VEC_LO) |-> state_r.ps[`CRS_FLAG_I] ##1 state_r.ps[`CRS_FLAG_I];
    endproperty
    a_inhibit_reset: assert property (p_inhibit_reset) else $error("inhibit flag low after reset");

    // Vector fetch order
    property p_vec_order;
        (state_r.st == S_VEC_LO) |-> (o_mem_rd && o_mem_addr == 16'hFFFE) ##1 (o_mem_rd && o_mem_addr == 16'hFFFF);
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("vector fetch order wrong");

    // Counter assembled from both vector bytes
    property p_vec_load;
        (state_r.st == S_VEC_HI) |=> (o_program_counter == {$past(i_mem_rdata), $past(i_mem_rdata, 2)}) && o_ready;
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("counter not loaded from vector");

    // Stack page high byte
    property p_stack_page;
        o_stack_addr[15:8] == (state_r.stk_page ? 8'h01 : 8'h00);
    endproperty
    a_stack_page: assert property (p_stack_page) else $error("stack high byte wrong");

    // Mode register write reaches page select
    property p_mode_write;
        (i_sfr_wr && i_sfr_addr == 8'hFB) |=> (state_r.stk_page == $past(i_sfr_wdata[2]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("page select not written");

    // Carry assert and clear
    property p_carry_ops;
        (op_take && (i_op == OP_CARRY_ASSERT || i_op == OP_CARRY_CLEAR))
            |=> (o_processor_status[0] == ($past(i_op) == OP_CARRY_ASSERT));
    endproperty
    a_carry_ops: assert property (p_carry_ops) else $error("carry op failed");

    // Carry follows the arithmetic unit
    property p_carry_alu;
        (op_take && (i_op == OP_ALU || i_op == OP_SHIFT)) |=> (o_processor_status[0] == $past(i_alu_carry));
    endproperty
    a_carry_alu: assert property (p_carry_alu) else $error("carry not captured");

    // Push writes at stack address then decrements
    property p_push;
        (op_take && (i_op == OP_ACC_PUSH || i_op == OP_FLAGS_PUSH))
            |=> o_mem_wr && (o_mem_addr[7:0] == $past(state_r.sp)) && (state_r.sp == $past(state_r.sp) - 8'h01)
            ##1 (!o_mem_wr || $past(op_take));
    endproperty
    a_push: assert property (p_push) else $error("push sequence wrong");

    // Pull increments then reads, one cycle busy
    property p_pull;
        (op_take && (i_op == OP_ACC_POP || i_op == OP_FLAGS_POP))
            |=> o_mem_rd && (state_r.sp == $past(state_r.sp) + 8'h01) && (o_mem_addr[7:0] == state_r.sp) && !o_ready
            ##1 o_ready;
    endproperty
    a_pull: assert property (p_pull) else $error("pull sequence wrong");

    // Interrupt accept sets inhibit and blocks requests
    property p_int_accept;
        (op_take && i_op == OP_INT_ACCEPT) |=> o_processor_status[2] && (!i_irq_req || i_break_req || !o_irq_take);
    endproperty
    a_int_accept: assert property (p_int_accept) else $error("inhibit not set on accept");

    // Zero and negative flags held in decimal mode
    property p_decimal_hold;
        (op_take && i_op == OP_ALU && state_r.ps[3]) |=> $stable(o_processor_status[1]) && $stable(o_processor_status[7]);
    endproperty
    a_decimal_hold: assert property (p_decimal_hold) else $error("flag changed in decimal mode");

    // Main scenarios
    property p_cov_push_pull;
        (op_take && i_op == OP_ACC_PUSH) ##[1:20] (op_take && i_op == OP_ACC_POP);
    endproperty
    c_push_pull: cover property (p_cov_push_pull);

    property p_cov_page1;
        state_r.stk_page && o_mem_wr;
    endproperty
    c_page1: cover property (p_cov_page1);

    property p_cov_wait;
        o_waiting ##1 o_ready;
    endproperty
    c_wait: cover property (p_cov_wait);

endmodule
`default_nettype wire

// ===== core/crs_pkg.sv
package crs_pkg;

    // Operation codes from the decoder; unlisted codes act as no operation
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_LD_ACC = 5'h01,
        OP_LD_X = 5'h02,
        OP_LD_Y = 5'h03,
        OP_LD_SP = 5'h04,
        OP_ALU = 5'h05,
        OP_SHIFT = 5'h06,
        OP_CARRY_ASSERT = 5'h07,
        OP_CARRY_CLEAR = 5'h08,
        OP_ACC_PUSH = 5'h09,
        OP_ACC_POP = 5'h0A,
        OP_FLAGS_PUSH = 5'h0B,
        OP_FLAGS_POP = 5'h0C,
        OP_INT_ACCEPT = 5'h0D,
        OP_INT_SET = 5'h0E,
        OP_INT_CLR = 5'h0F,
        OP_DEC_SET = 5'h10,
        OP_DEC_CLR = 5'h11,
        OP_PC_INC = 5'h12,
        OP_PC_LOAD = 5'h13,
        OP_PRODUCT = 5'h14,
        OP_DIVIDE = 5'h15,
        OP_WAIT = 5'h16,
        OP_HALT = 5'h17
    } crs_op_type;

    // Sequencer states
    typedef enum logic [2:0] {
        S_VEC_LO = 3'b000,
        S_VEC_HI = 3'b001,
        S_RUN = 3'b010,
        S_PULL = 3'b011,
        S_HALT = 3'b100,
        S_WAIT = 3'b101
    } crs_state_type;

    // Flag tested by a conditional branch
    typedef enum logic [1:0] {
        COND_C = 2'b00,
        COND_Z = 2'b01,
        COND_V = 2'b10,
        COND_N = 2'b11
    } crs_cond_type;

    // Whole state of the register set
    typedef struct packed {
        crs_state_type st;
        logic [7:0] acc;
        logic [7:0] idx_x;
        logic [7:0] idx_y;
        logic [7:0] sp;
        logic [7:0] ps;
        logic [15:0] pc;
        logic stk_page;
        logic pull_to_ps;
        logic mem_rd;
        logic mem_wr;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
    } crs_regs_type;

endpackage

// ===== core/crs_regs.svh
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// Zero-page address of the processor mode control register
`define CRS_MODE_ADDR 8'hFB
// Stack page select position inside that register
`define CRS_STK_PAGE_BIT 2

// Reset vector addresses
`define CRS_VEC_LO 16'hFFFE
`define CRS_VEC_HI 16'hFFFF

// Stack high byte for each page select value
`define CRS_PAGE0_HI 8'h00
`define CRS_PAGE1_HI 8'h01

// Processor status flag positions
`define CRS_FLAG_C 0
`define CRS_FLAG_Z 1
`define CRS_FLAG_I 2
`define CRS_FLAG_D 3
`define CRS_FLAG_B 4
`define CRS_FLAG_T 5
`define CRS_FLAG_V 6
`define CRS_FLAG_N 7

// Status value at reset: only interrupt inhibit set
`define CRS_PS_RST 8'h04

`endif

// ===== tb/crs_tb_mem.sv
`timescale 1ns/1ps
`default_nettype none

module crs_tb_mem #(
    parameter logic [15:0] VEC = 16'h0000,
    parameter bit PAGE1_RAM = 1'b1
) (
    // Clock
    input wire logic i_clk,
    // Memory port from the register set
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic present;

    // Reset vector bytes, low byte below high byte
    initial begin
        mem[16'hFFFE] = VEC[7:0];
        mem[16'hFFFF] = VEC[15:8];
        last_q = 8'h00;
    end

    // Small parts have no RAM in page one
    assign present = PAGE1_RAM || (i_addr[15:8] != 8'h01);

    // Write port and last read byte
    always @(posedge i_clk) begin
        if (i_wr && present) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_rd) begin
            last_q <= o_rdata;
        end
    end

    // Same-cycle read; released bus shows the inverse of the last byte
    assign o_rdata = (i_rd && present) ? mem[i_addr] : ~last_q;
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import crs_pkg::*;
    localparam logic [15:0] VEC = 16'hC3A5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    crs_op_type op = OP_NOP;
    logic [7:0] data = 8'h00;
    logic [15:0] pc_ld = 16'h0000;
    logic wake = 1'b0;
    logic [7:0] alu_res = 8'h00;
    logic alu_c = 1'b0;
    logic alu_v = 1'b0;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic irq = 1'b0;
    logic soft_break_op = 1'b0;
    crs_cond_type br_cond = COND_C;
    logic br_want = 1'b0;
    logic mem_rd, mem_wr, irq_take, br_take, dec, ready, waiting, halted;
    logic [15:0] mem_addr, stk_addr, pc, s_addr;
    logic [7:0] mem_wdata, mem_rdata, sfr_rdata, acc, idx_x, idx_y, sp, ps, s_wdata;
    logic s_wr, s_rd;
    int n_mismatch = 0;
    int cmp_count = 0;

    // Clock
    initial begin
        forever #25 clk = ~clk;
    end

    crs_core_regs i_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_op_valid(op_valid), .i_op(op), .i_data(data),
        .i_pc_load(pc_ld), .i_wake(wake), .i_alu_result(alu_res), .i_alu_carry(alu_c),
        .i_alu_ovf(alu_v), .i_mem_rdata(mem_rdata), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr),
        .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_sfr_wr(sfr_wr), .i_sfr_addr(sfr_addr),
        .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_irq_req(irq), .i_break_req(soft_break_op),
        .o_irq_take(irq_take), .i_br_cond(br_cond), .i_br_want(br_want), .o_br_take(br_take),
        .o_acc(acc), .o_idx_x(idx_x), .o_idx_y(idx_y), .o_stack_ptr(sp), .o_stack_addr(stk_addr),
        .o_program_counter(pc), .o_processor_status(ps), .o_decimal(dec), .o_ready(ready),
        .o_waiting(waiting), .o_halted(halted)
    );

    crs_tb_mem #(.VEC(VEC), .PAGE1_RAM(1'b1)) i_mem (
        .i_clk(clk), .i_rd(mem_rd), .i_wr(mem_wr), .i_addr(mem_addr), .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One operation, memory strobes captured in the cycle after acceptance
    task automatic do_op(input crs_op_type o, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (ready !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        op_valid = 1'b1;
        op = o;
        data = d;
        @(negedge clk);
        op_valid = 1'b0;
        {s_wr, s_rd, s_addr, s_wdata} = {mem_wr, mem_rd, mem_addr, mem_wdata};
        // Wait and halt never return to ready on their own
        while (ready !== 1'b1 && n < 20 && o != OP_WAIT && o != OP_HALT) begin
            n++;
            @(negedge clk);
        end
        // Ready that never comes counts as a mismatch
        if (n >= 20) begin
            n_mismatch++;
            test_done();
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic t_reset;
        chk("status", {8'h00, ps}, 16'h0004);
        chk("pc", pc, VEC);
        chk("stack hi", {8'h00, stk_addr[15:8]}, 16'h0000);
        sfr_addr = 8'hFB;
        #1 chk("mode", {8'h00, sfr_rdata}, 16'h0000);
    endtask

    task automatic t_regs;
        do_op(OP_LD_ACC, 8'h5A);
        chk("acc", {8'h00, acc}, 16'h005A);
        do_op(OP_LD_X, 8'hA5);
        chk("x", {8'h00, idx_x}, 16'h00A5);
        do_op(OP_LD_Y, 8'h3C);
        chk("y", {8'h00, idx_y}, 16'h003C);
        do_op(OP_LD_SP, 8'h80);
        chk("sp", stk_addr, 16'h0080);
    endtask

    // Push both, then pull in reverse order
    task automatic t_stack(input logic [7:0] hi);
        do_op(OP_ACC_PUSH, 8'h00);
        chk("push acc", {s_wr, 7'h00, s_wdata}, 16'h805A);
        chk("push acc addr", s_addr, {hi, 8'h80});
        do_op(OP_FLAGS_PUSH, 8'h00);
        chk("push ps", {s_wr, 7'h00, s_wdata}, 16'h8004);
        chk("push ps addr", s_addr, {hi, 8'h7F});
        chk("sp", {8'h00, sp}, 16'h007E);
        do_op(OP_CARRY_ASSERT, 8'h00);
        do_op(OP_LD_ACC, 8'h00);
        do_op(OP_FLAGS_POP, 8'h00);
        chk("pull rd", {15'h0, s_rd}, 16'h0001);
        chk("pull ps addr", s_addr, {hi, 8'h7F});
        chk("ps", {8'h00, ps}, 16'h0004);
        do_op(OP_ACC_POP, 8'h00);
        chk("acc", {8'h00, acc}, 16'h005A);
        chk("stack", stk_addr, {hi, 8'h80});
    endtask

    task automatic t_page;
        sfr_write(8'hFB, 8'h04);
        chk("page", stk_addr, 16'h0180);
        #1 chk("mode", {8'h00, sfr_rdata}, 16'h0004);
        sfr_write(8'hFA, 8'h00);
        chk("other", stk_addr, 16'h0180);
        t_stack(8'h01);
        sfr_write(8'hFB, 8'h00);
        chk("page", stk_addr, 16'h0080);
    endtask

    // Result is zero with carry and overflow: C, Z, V set, N clear
    task automatic t_flags;
        do_op(OP_CARRY_CLEAR, 8'h00);
        chk("c clr", {15'h0, ps[0]}, 16'h0000);
        {alu_res, alu_c, alu_v} = {8'h00, 1'b1, 1'b1};
        do_op(OP_ALU, 8'h00);
        chk("alu", {8'h00, ps[7:6], 4'h0, ps[1:0]}, 16'h0043);
        br_want = 1'b1;
        for (int k = 0; k < 4; k++) begin
            br_cond = crs_cond_type'(k);
            #1 chk("branch", {15'h0, br_take}, {15'h0, k != 3});
        end
        alu_c = 1'b0;
        do_op(OP_SHIFT, 8'h00);
        chk("shift", {15'h0, ps[0]}, 16'h0000);
        do_op(OP_DEC_SET, 8'h00);
        chk("dec", {14'h0, dec, ps[3]}, 16'h0003);
        // Negative nonzero result: only carry may move in decimal mode
        {alu_res, alu_c} = {8'h80, 1'b1};
        do_op(OP_ALU, 8'h00);
        chk("dec c", {8'h00, ps}, 16'h004F);
        do_op(OP_DEC_CLR, 8'h00);
        chk("dec", {15'h0, dec}, 16'h0000);
    endtask

    task automatic t_int;
        irq = 1'b1;
        #1 chk("masked", {15'h0, irq_take}, 16'h0000);
        soft_break_op = 1'b1;
        #1 chk("break", {15'h0, irq_take}, 16'h0001);
        soft_break_op = 1'b0;
        do_op(OP_INT_CLR, 8'h00);
        chk("open", {15'h0, irq_take}, 16'h0001);
        do_op(OP_INT_ACCEPT, 8'h00);
        chk("accept", {14'h0, ps[2], irq_take}, 16'h0002);
        do_op(OP_INT_CLR, 8'h00);
        do_op(OP_INT_SET, 8'h00);
        chk("set", {14'h0, ps[2], irq_take}, 16'h0002);
        irq = 1'b0;
    endtask

    task automatic t_misc;
        pc_ld = 16'h12FF;
        do_op(OP_PC_LOAD, 8'h00);
        do_op(OP_PC_INC, 8'h00);
        chk("pc", pc, 16'h1300);
        do_op(OP_LD_ACC, 8'h10);
        do_op(OP_PRODUCT, 8'h31);
        chk("product", {idx_y, acc}, 16'h0310);
        do_op(OP_DIVIDE, 8'h10);
        chk("divide", {idx_y, acc}, 16'h0031);
        do_op(crs_op_type'(5'h1F), 8'hEE);
        chk("unlisted", {idx_y, acc}, 16'h0031);
        do_op(OP_WAIT, 8'h00);
        chk("wait", {15'h0, waiting}, 16'h0001);
        wake = 1'b1;
        do_op(OP_NOP, 8'h00);
        wake = 1'b0;
        chk("woken", {14'h0, waiting, ready}, 16'h0001);
        do_op(OP_HALT, 8'h00);
        chk("halt", {14'h0, halted, ready}, 16'h0002);
    endtask

    // Second reset from halt with page one selected
    task automatic t_rerun;
        sfr_write(8'hFB, 8'h04);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("in reset", {14'h0, halted, ready}, 16'h0000);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_regs();
        t_stack(8'h00);
        t_page();
        t_flags();
        t_int();
        t_misc();
        t_rerun();
        test_done();
    end
endmodule
`default_nettype wire
